/* bcbd_branch_cond.sv */
// branch condition evaluator for the relative branch group
// assumes condition codes and pin level are stable in the start cycle
`timescale 1ns/1ps
module bcbd_branch_cond (
	input wire logic [7:0] opcode,
	input wire logic [4:0] cc,
	input wire logic irq_pin,
	output logic is_branch,
	output logic take
);
	// ---------------------------------------------------------------
	// condition table
	// ---------------------------------------------------------------
	// pin branches look at the live pin, never a latched request
	always_comb
	begin
		is_branch = 1'b1;
		take = 1'b0;
		unique case (opcode)
			bcbd_pkg::OP_BR_UGT: take = ~(cc[bcbd_pkg::CC_C] | cc[bcbd_pkg::CC_Z]);
			bcbd_pkg::OP_BR_ULE: take = cc[bcbd_pkg::CC_C] | cc[bcbd_pkg::CC_Z];
			bcbd_pkg::OP_BR_CC: take = ~cc[bcbd_pkg::CC_C];
			bcbd_pkg::OP_BR_CS: take = cc[bcbd_pkg::CC_C];
			bcbd_pkg::OP_BR_EQ: take = cc[bcbd_pkg::CC_Z];
			bcbd_pkg::OP_BR_HCC: take = ~cc[bcbd_pkg::CC_H];
			bcbd_pkg::OP_BR_HCS: take = cc[bcbd_pkg::CC_H];
			bcbd_pkg::OP_BR_PINL: take = ~irq_pin;
			bcbd_pkg::OP_BR_PINH: take = irq_pin;
			default: is_branch = 1'b0;
		endcase
	end
endmodule // bcbd_branch_cond

/* bcbd_core.sv */
// decode and execute of clear-bit, relative branch and and-test opcodes
// assumes the fetch path hands over opcode and operand bytes with start,
// and data memory answers a read in the same cycle (asynchronous read)
`timescale 1ns/1ps
module bcbd_core (
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] op1,
	input wire logic [7:0] op2,
	input wire logic [11:0] pc_in,
	input wire logic [4:0] cc_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] x_in,
	input wire logic irq_pin,
	input wire logic [7:0] mem_rdata,
	output logic busy,
	output logic done,
	output logic illegal,
	output logic [11:0] pc_out,
	output logic [4:0] cc_out,
	output logic [11:0] mem_addr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	bcbd_pkg::bcbd_state_t state;
	bcbd_pkg::bcbd_mode_t mode;
	logic [2:0] cnt;
	logic is_clr;
	logic is_tst;
	logic is_branch;
	logic take;
	logic legal;
	logic needs_read;
	logic [2:0] next_cyc;
	logic [11:0] next_len;
	logic [11:0] next_pc;
	logic [11:0] ea;
	logic [11:0] rel_ext;
	logic start_ok;
	logic clr_q;
	logic tst_q;
	logic [2:0] bit_q;
	logic [7:0] acc_q;
	logic [7:0] and_res;

	assign start_ok = start & ~busy;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// clear-bit: mask keeps the odd low bit and the 1x high nibble
	assign is_clr = (opcode & bcbd_pkg::CLR_MASK) == bcbd_pkg::OP_CLR_BASE;
	assign is_tst = (opcode[3:0] == bcbd_pkg::TST_LO) && (opcode[7:4] >= bcbd_pkg::TST_HI_IMM);
	// one signed offset byte follows the opcode
	assign rel_ext = {{4{op1[7]}}, op1};

	bcbd_branch_cond u_cond (
		.opcode(opcode),
		.cc(cc_in),
		.irq_pin(irq_pin),
		.is_branch(is_branch),
		.take(take)
	);

	bcbd_ea_gen u_ea (
		.mode(mode),
		.op1(op1),
		.op2(op2),
		.x(x_in),
		.ea(ea)
	);

	// cycle count, length and operand source per opcode
	always_comb
	begin
		legal = 1'b1;
		needs_read = 1'b0;
		next_cyc = bcbd_pkg::CYC_BR_NT;
		next_len = bcbd_pkg::LEN_2;
		mode = bcbd_pkg::MODE_DIR;
		if (is_clr)
		begin
			needs_read = 1'b1;
			next_cyc = bcbd_pkg::CYC_CLR;
		end
		else if (is_branch)
		begin
			next_cyc = take ? bcbd_pkg::CYC_BR_T : bcbd_pkg::CYC_BR_NT;
		end
		else if (is_tst)
		begin
			needs_read = 1'b1;
			unique case (opcode[7:4])
				bcbd_pkg::TST_HI_IMM:
				begin
					mode = bcbd_pkg::MODE_IMM;
					needs_read = 1'b0;
					next_cyc = bcbd_pkg::CYC_TST_IMM;
				end
				bcbd_pkg::TST_HI_DIR: next_cyc = bcbd_pkg::CYC_TST_DIR;
				bcbd_pkg::TST_HI_EXT:
				begin
					mode = bcbd_pkg::MODE_EXT;
					next_cyc = bcbd_pkg::CYC_TST_EXT;
					next_len = bcbd_pkg::LEN_3;
				end
				bcbd_pkg::TST_HI_IX2:
				begin
					mode = bcbd_pkg::MODE_IX2;
					next_cyc = bcbd_pkg::CYC_TST_IX2;
					next_len = bcbd_pkg::LEN_3;
				end
				bcbd_pkg::TST_HI_IX1:
				begin
					mode = bcbd_pkg::MODE_IX1;
					next_cyc = bcbd_pkg::CYC_TST_IX1;
				end
				bcbd_pkg::TST_HI_IX0:
				begin
					mode = bcbd_pkg::MODE_IX0;
					next_cyc = bcbd_pkg::CYC_TST_IX0;
					next_len = bcbd_pkg::LEN_1;
				end
				default: legal = 1'b0;
			endcase
		end
		else
		begin
			legal = 1'b0;
		end
	end

	// taken branch adds the offset on top of the step past the branch
	assign next_pc = (is_branch && take) ? pc_in + next_len + rel_ext : pc_in + next_len;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// a single down-counter pads every instruction to its cycle count
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= bcbd_pkg::ST_IDLE;
			cnt <= 3'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			unique case (state)
				bcbd_pkg::ST_IDLE:
				begin
					if (start_ok && !legal)
					begin
						done <= 1'b1;
					end
					else if (start_ok)
					begin
						busy <= 1'b1;
						cnt <= next_cyc - 3'h1;
						state <= needs_read ? bcbd_pkg::ST_RMEM : bcbd_pkg::ST_WAIT;
					end
				end
				default:
				begin
					cnt <= cnt - 3'h1;
					state <= bcbd_pkg::ST_WAIT;
					if (cnt == 3'h1)
					begin
						done <= 1'b1;
						busy <= 1'b0;
						state <= bcbd_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// latched instruction context
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			clr_q <= 1'b0;
			tst_q <= 1'b0;
			bit_q <= 3'h0;
			acc_q <= 8'h00;
			illegal <= 1'b0;
		end
		else if (start_ok)
		begin
			clr_q <= is_clr;
			tst_q <= is_tst & legal;
			bit_q <= opcode[3:1];
			acc_q <= acc_in;
			illegal <= ~legal;
		end
	end

	// ---------------------------------------------------------------
	// data memory port
	// ---------------------------------------------------------------
	// read in the cycle after start, clear-bit writes back one cycle later
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mem_addr <= 12'h000;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
		end
		else
		begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			if (state == bcbd_pkg::ST_IDLE && start_ok && legal && needs_read)
			begin
				mem_rd <= 1'b1;
				mem_addr <= ea;
			end
			if (state == bcbd_pkg::ST_RMEM && clr_q)
			begin
				mem_wr <= 1'b1;
				mem_wdata <= mem_rdata & ~(8'h01 << bit_q);
			end
		end
	end

	// ---------------------------------------------------------------
	// program counter and condition codes
	// ---------------------------------------------------------------
	// the accumulator is never written back, so and-test leaves it alone
	assign and_res = (state == bcbd_pkg::ST_RMEM) ? (acc_q & mem_rdata) : (acc_in & op1);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pc_out <= 12'h000;
			cc_out <= 5'h00;
		end
		else if (state == bcbd_pkg::ST_IDLE && start_ok)
		begin
			// illegal opcodes report the entry pc unchanged
			pc_out <= legal ? next_pc : pc_in;
			cc_out <= cc_in;
			if (is_tst && mode == bcbd_pkg::MODE_IMM)
			begin
				cc_out[bcbd_pkg::CC_N] <= and_res[7];
				cc_out[bcbd_pkg::CC_Z] <= and_res == 8'h00;
			end
		end
		else if (state == bcbd_pkg::ST_RMEM && tst_q)
		begin
			cc_out[bcbd_pkg::CC_N] <= and_res[7];
			cc_out[bcbd_pkg::CC_Z] <= and_res == 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_CLR_LEN: assert property (start_ok && is_clr |-> ##4 done
		&& pc_out == $past(pc_in, 4) + 12'h002)
		else $error("clear-bit length or timing wrong");
	AST_CLR_WDATA: assert property (state == bcbd_pkg::ST_RMEM && clr_q |=> mem_wr && mem_wdata == ($past(mem_rdata) & ~(8'h01 << bit_q)))
		else $error("clear-bit write data wrong");
	AST_CLR_CC: assert property (start_ok && is_clr |-> ##4 cc_out == $past(cc_in, 4))
		else $error("clear-bit altered flags");
	AST_BR_TAKEN: assert property (start_ok && is_branch && take |-> ##3 done
		&& pc_out == $past(pc_in, 3) + 12'h002 + {{4{$past(op1[7], 3)}}, $past(op1, 3)})
		else $error("taken branch target or timing wrong");
	AST_BR_NOT: assert property (start_ok && is_branch && !take |-> ##2 done
		&& pc_out == $past(pc_in, 2) + 12'h002)
		else $error("untaken branch wrong");
	// done two cycles after start only when the branch falls through
	AST_UGT: assert property (start_ok && opcode == bcbd_pkg::OP_BR_UGT |-> ##2 done ==
		($past(cc_in[bcbd_pkg::CC_C], 2) || $past(cc_in[bcbd_pkg::CC_Z], 2)))
		else $error("greater-than condition wrong");
	AST_PIN_HIGH: assert property (start_ok && opcode == bcbd_pkg::OP_BR_PINH && irq_pin
		|=> busy ##2 done)
		else $error("pin-high branch not taken");
	AST_PIN_LOW: assert property (start_ok && opcode == bcbd_pkg::OP_BR_PINL && irq_pin
		|-> ##2 done)
		else $error("pin-low branch taken on high pin");
	AST_TST_FLAGS: assert property (state == bcbd_pkg::ST_RMEM && tst_q |=> cc_out[bcbd_pkg::CC_N] == $past(acc_q[7] & mem_rdata[7]) && cc_out[bcbd_pkg::CC_Z] == ($past(acc_q & mem_rdata) == 8'h00))
		else $error("and-test flags wrong");
	AST_TST_KEEP: assert property (start_ok && is_tst |=> cc_out[bcbd_pkg::CC_C] == $past(cc_in[bcbd_pkg::CC_C]) && cc_out[bcbd_pkg::CC_H] == $past(cc_in[bcbd_pkg::CC_H]))
		else $error("and-test changed kept flags");
	AST_TST_IX2: assert property (start_ok && opcode == 8'hd5 |-> ##5 done
		&& pc_out == $past(pc_in, 5) + 12'h003)
		else $error("two-byte offset test timing wrong");
	AST_TST_IX0: assert property (start_ok && opcode == 8'hf5 |=> mem_rd
		&& mem_addr == {4'h0, $past(x_in)} ##1 done && !mem_rd)
		else $error("zero-offset test timing wrong");

	COV_CLR: cover property (start_ok && is_clr ##4 done);
	COV_BR_TAKEN: cover property (start_ok && is_branch && take ##3 done);
	COV_TST_DIR: cover property (start_ok && opcode == 8'hb5 ##3 done);
endmodule // bcbd_core

/* bcbd_data_mem.sv */
// data memory model standing beside the decode block
// assumes the block strobes mem_rd and mem_wr for one clock each
`timescale 1ns/1ps
module bcbd_data_mem (
	input wire logic clk,
	input wire logic [11:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [7:0] mem [0:4095];
	logic [7:0] last = 8'h5a;

	// asynchronous read; off the strobe the bus shows junk, not the old byte
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;

	// remember the last byte so the junk differs from it
	always @(posedge clk)
	begin
		if (mem_rd)
			last <= mem[mem_addr];
	end

	// plain always: the bench also presets bytes by hierarchy
	always @(posedge clk)
	begin
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
endmodule // bcbd_data_mem

/* bcbd_ea_gen.sv */
// effective address generator for direct, extended and indexed modes
// assumes a 12-bit data address space; index sums wrap at 12 bits
`timescale 1ns/1ps
module bcbd_ea_gen (
	input wire bcbd_pkg::bcbd_mode_t mode,
	input wire logic [7:0] op1,
	input wire logic [7:0] op2,
	input wire logic [7:0] x,
	output logic [11:0] ea
);
	// ---------------------------------------------------------------
	// address forming
	// ---------------------------------------------------------------
	// two-byte forms drop the top nibble of the high byte
	always_comb
	begin
		unique case (mode)
			bcbd_pkg::MODE_EXT: ea = {op1[3:0], op2};
			bcbd_pkg::MODE_IX2: ea = {op1[3:0], op2} + {4'h0, x};
			bcbd_pkg::MODE_IX1: ea = {4'h0, op1} + {4'h0, x};
			bcbd_pkg::MODE_IX0: ea = {4'h0, x};
			default: ea = {4'h0, op1};
		endcase
	end
endmodule // bcbd_ea_gen

/* bcbd_pkg.sv */
// constants for the bit clear, branch and and-test decode block
// assumes one machine cycle per clock at 10 MHz
package bcbd_pkg;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] CLR_MASK = 8'hf1;
	localparam logic [7:0] OP_CLR_BASE = 8'h11;
	localparam logic [7:0] OP_BR_UGT = 8'h22;
	localparam logic [7:0] OP_BR_ULE = 8'h23;
	localparam logic [7:0] OP_BR_CC = 8'h24;
	localparam logic [7:0] OP_BR_CS = 8'h25;
	localparam logic [7:0] OP_BR_EQ = 8'h27;
	localparam logic [7:0] OP_BR_HCC = 8'h28;
	localparam logic [7:0] OP_BR_HCS = 8'h29;
	localparam logic [7:0] OP_BR_PINL = 8'h2e;
	localparam logic [7:0] OP_BR_PINH = 8'h2f;
	localparam logic [3:0] TST_LO = 4'h5;
	localparam logic [3:0] TST_HI_IMM = 4'ha;
	localparam logic [3:0] TST_HI_DIR = 4'hb;
	localparam logic [3:0] TST_HI_EXT = 4'hc;
	localparam logic [3:0] TST_HI_IX2 = 4'hd;
	localparam logic [3:0] TST_HI_IX1 = 4'he;
	localparam logic [3:0] TST_HI_IX0 = 4'hf;
	// ---------------------------------------------------------------
	// condition code bit positions
	// ---------------------------------------------------------------
	localparam int CC_C = 0;
	localparam int CC_Z = 1;
	localparam int CC_N = 2;
	localparam int CC_I = 3;
	localparam int CC_H = 4;
	// ---------------------------------------------------------------
	// machine cycle counts and lengths in bytes
	// ---------------------------------------------------------------
	localparam logic [2:0] CYC_CLR = 3'h4;
	localparam logic [2:0] CYC_BR_NT = 3'h2;
	localparam logic [2:0] CYC_BR_T = 3'h3;
	localparam logic [2:0] CYC_TST_IMM = 3'h2;
	localparam logic [2:0] CYC_TST_DIR = 3'h3;
	localparam logic [2:0] CYC_TST_EXT = 3'h4;
	localparam logic [2:0] CYC_TST_IX2 = 3'h5;
	localparam logic [2:0] CYC_TST_IX1 = 3'h4;
	localparam logic [2:0] CYC_TST_IX0 = 3'h2;
	localparam logic [11:0] LEN_1 = 12'h001;
	localparam logic [11:0] LEN_2 = 12'h002;
	localparam logic [11:0] LEN_3 = 12'h003;
	// ---------------------------------------------------------------
	// operand addressing modes and sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_IMM = 3'b000,
		MODE_DIR = 3'b001,
		MODE_EXT = 3'b010,
		MODE_IX2 = 3'b011,
		MODE_IX1 = 3'b100,
		MODE_IX0 = 3'b101
	} bcbd_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RMEM = 2'b01,
		ST_WAIT = 2'b10
	} bcbd_state_t;
endpackage

/* tb_bit_clear_and_branch_decode.sv */
// self-checking bench for the clear-bit, branch and and-test decode block
// assumes the data memory model file is compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb_bit_clear_and_branch_decode;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [7:0] op1 = 8'h00;
	logic [7:0] op2 = 8'h00;
	logic [11:0] pc_in = 12'h000;
	logic [4:0] cc_in = 5'h00;
	logic [7:0] acc_in = 8'h00;
	logic [7:0] x_in = 8'h00;
	logic irq_pin = 1'b0;
	logic [7:0] mem_rdata;
	logic busy, done, illegal, mem_rd, mem_wr;
	logic [11:0] pc_out, mem_addr;
	logic [4:0] cc_out;
	logic [7:0] mem_wdata;
	int err_total = 0;
	int compares = 0;

	// 100 ns period
	initial
	begin
		forever #50 clk = ~clk;
	end

	bcbd_core u_dut (.clk(clk), .reset(reset), .start(start), .opcode(opcode), .op1(op1),
		.op2(op2), .pc_in(pc_in), .cc_in(cc_in), .acc_in(acc_in), .x_in(x_in),
		.irq_pin(irq_pin), .mem_rdata(mem_rdata), .busy(busy), .done(done),
		.illegal(illegal), .pc_out(pc_out), .cc_out(cc_out), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata));

	bcbd_data_mem u_mem (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task results;
		$display("counts: %0d compares, %0d mismatches", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one instruction at a negedge, then cycles, pc, flags and illegal judged
	task exec(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
		input logic [11:0] pc, input logic [4:0] cc, input logic [7:0] acc,
		input logic [7:0] x, input logic pin, input int cyc, input logic [11:0] epc,
		input logic [4:0] ecc, input logic eill);
		int n;
		opcode = op;
		op1 = o1;
		op2 = o2;
		pc_in = pc;
		cc_in = cc;
		acc_in = acc;
		x_in = x;
		irq_pin = pin;
		start = 1'b1;
		@(posedge clk);
		@(negedge clk);
		start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 10)
		begin
			@(negedge clk);
			n++;
		end
		if (done !== 1'b1)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: no done", $time);
			results();
		end
		else
		begin
			`CHK(n, cyc)
			`CHK(pc_out, epc)
			`CHK(cc_out, ecc)
			`CHK(illegal, eill)
			`CHK(busy, 1'b0)
		end
	endtask

	// branch decision worked out from the flag and pin conditions
	function automatic logic taken(input logic [7:0] op, input logic [4:0] cc, input logic pin);
		case (op)
			8'h22: return !(cc[0] | cc[1]);
			8'h23: return cc[0] | cc[1];
			8'h24: return !cc[0];
			8'h25: return cc[0];
			8'h27: return cc[1];
			8'h28: return !cc[4];
			8'h29: return cc[4];
			8'h2e: return !pin;
			default: return pin;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task test_clear;
		logic [7:0] v;
		for (int n = 0; n < 8; n++)
		begin
			v = 8'hda | (8'h01 << n);
			u_mem.mem[12'h040 + 12'(n)] = v;
			exec(8'h11 + 8'(2 * n), 8'h40 + 8'(n), 8'h00, 12'h7fe, 5'h15, 8'h00, 8'h00, 1'b0,
				4, 12'h800, 5'h15, 1'b0);
			`CHK(u_mem.mem[12'h040 + 12'(n)], v & ~(8'h01 << n))
		end
		$display("clear bit test done");
	endtask

	// every branch opcode against flag patterns, both pin levels, both offset signs
	task test_branch;
		logic [7:0] ops [9];
		logic [4:0] ccs [6];
		logic [7:0] off;
		logic [11:0] pc;
		logic pin, t;
		ops = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h28, 8'h29, 8'h2e, 8'h2f};
		ccs = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h1f};
		for (int i = 0; i < 9; i++)
			for (int j = 0; j < 6; j++)
			begin
				off = j[0] ? 8'h80 : 8'h7f;
				pc = j[1] ? 12'hffe : 12'h123;
				pin = j[2] ^ j[0];
				t = taken(ops[i], ccs[j], pin);
				exec(ops[i], off, 8'h00, pc, ccs[j], 8'h00, 8'h00, pin, t ? 3 : 2,
					t ? pc + 12'h002 + {{4{off[7]}}, off} : pc + 12'h002, ccs[j],
					1'b0);
			end
		$display("branch test done");
	endtask

	// an opcode outside the group finishes at once with nothing changed
	task test_illegal;
		exec(8'h20, 8'h10, 8'h00, 12'h300, 5'h0a, 8'h00, 8'h00, 1'b0, 1, 12'h300, 5'h0a, 1'b1);
		$display("illegal opcode test done");
	endtask

	task and_case(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
		input logic [7:0] x, input logic [11:0] a, input logic [7:0] m, input logic [4:0] cc,
		input int cyc, input logic [11:0] len);
		logic [7:0] r;
		u_mem.mem[a] = m;
		r = 8'hf0 & ((op == 8'ha5) ? o1 : m);
		exec(op, o1, o2, 12'h100, cc, 8'hf0, x, 1'b0, cyc, 12'h100 + len,
			{cc[4:3], r[7], r == 8'h00, cc[0]}, 1'b0);
		`CHK(u_mem.mem[a], m)
	endtask

	// all six operand modes, flags flanked both ways
	task test_and;
		and_case(8'ha5, 8'h80, 8'h00, 8'h00, 12'h000, 8'h00, 5'h06, 2, 12'h002);
		and_case(8'hb5, 8'h50, 8'h00, 8'h00, 12'h050, 8'h0f, 5'h1d, 3, 12'h002);
		and_case(8'hc5, 8'h02, 8'h34, 8'h00, 12'h234, 8'hff, 5'h00, 4, 12'h003);
		and_case(8'hd5, 8'h0f, 8'hff, 8'h02, 12'h001, 8'h01, 5'h19, 5, 12'h003);
		and_case(8'he5, 8'hf0, 8'h00, 8'h20, 12'h110, 8'h70, 5'h1f, 4, 12'h002);
		and_case(8'hf5, 8'h00, 8'h00, 8'h60, 12'h060, 8'h80, 5'h00, 2, 12'h001);
		$display("and-test test done");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		// first start only after an edge has seen reset low
		@(negedge clk);
		test_clear();
		test_branch();
		test_illegal();
		test_and();
		results();
	end
endmodule // tb_bit_clear_and_branch_decode
